//--- core/game_port_pkg.sv
// package: register map, field layout and timing constants of the game port
package game_port_pkg;

    // ========================================================================
    // register offsets
    localparam logic [9:0] OFS_STATUS_LO = 10'h000;
    localparam logic [9:0] OFS_STATUS_HI = 10'h001;
    localparam logic [9:0] OFS_XPOS_LO = 10'h008;
    localparam logic [9:0] OFS_XPOS_HI = 10'h009;
    localparam logic [9:0] OFS_YPOS_LO = 10'h00A;
    localparam logic [9:0] OFS_YPOS_HI = 10'h00B;
    localparam logic [9:0] OFS_CONTROL = 10'h00C;
    localparam logic [9:0] OFS_ALIAS_LO = 10'h200;
    localparam logic [9:0] OFS_ALIAS_HI = 10'h201;

    // ========================================================================
    // control register fields and reset
    localparam int CTL_POLL_BIT = 7;
    localparam int CTL_LEGACY_BIT = 6;
    localparam int CTL_CHOICE_BIT = 4;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ========================================================================
    // widths and timing
    localparam int POS_W = 13;
    localparam int AXES = 4;
    localparam int PORTS = 2;
    // least one-shot length in ns before an axis may end
    localparam int ONESHOT_MIN_NS = 20;
    localparam int CLK_NS = 20;
    localparam int ONESHOT_MIN_CYC =
        (ONESHOT_MIN_NS + CLK_NS - 1) / CLK_NS;

    // ========================================================================
    // carriers
    typedef struct packed {
        logic [9:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } host_req_s;

    typedef struct packed {
        logic [7:0] rdata;
        logic hit;
    } host_rsp_s;

    typedef struct packed {
        logic [AXES-1:0] comp;
        logic [3:0] button_n;
    } analog_pins_s;

endpackage

//--- core/axis_position_store.sv
// small register file holding captured axis counts per digital port
`timescale 1ns/1ps
module axis_position_store
    import game_port_pkg::*;
#(
    parameter int W = POS_W
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // write side: two entries per port, x and y
    input wire logic [PORTS*2-1:0] wr_en,
    input wire logic [PORTS*2*W-1:0] wr_data,
    // read side
    input wire logic rd_port,
    output logic [W-1:0] rd_x,
    output logic [W-1:0] rd_y
);
    typedef struct packed {
        logic [PORTS*2-1:0][W-1:0] mem;
        logic [W-1:0] x;
        logic [W-1:0] y;
    } store_s;

    store_s st_q;
    store_s st_d;

    // ========================================================================
    // entries 0/1 are port one x/y, 2/3 port two x/y
    always_comb
    begin
        st_d = st_q;
        for (int i = 0; i < PORTS*2; i++)
        begin
            if (wr_en[i])
            begin
                st_d.mem[i] = wr_data[i*W +: W];
            end
        end
        // registered read keeps data outputs off combinational paths
        st_d.x = st_q.mem[{rd_port, 1'b0}];
        st_d.y = st_q.mem[{rd_port, 1'b1}];
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rd_x = st_q.x;
    assign rd_y = st_q.y;
endmodule // axis_position_store

//--- core/joystick_game_port.sv
// game port: legacy status, control, axis one-shots and auto-poll counters
`timescale 1ns/1ps
module joystick_game_port
    import game_port_pkg::*;
#(
    parameter int W = POS_W
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // host register access
    input wire game_port_pkg::host_req_s req,
    output game_port_pkg::host_rsp_s rsp,
    // analog port pins
    input wire game_port_pkg::analog_pins_s pins,
    // one-shot trigger to the external timing network
    output logic trigger,
    // current control state
    output logic auto_poll_enable,
    output logic legacy_decode_enable
);
    import game_port_pkg::*;

    typedef enum logic [2:0] {
        POLL_IDLE = 3'b001,
        POLL_RUN = 3'b010,
        POLL_DONE = 3'b100
    } poll_e;

    typedef struct packed {
        analog_pins_s sync1;
        analog_pins_s sync2;
        logic [7:0] ctl;
        logic trig;
        logic [AXES-1:0] running;
        logic [AXES-1:0][W-1:0] count;
        logic [7:0] min_cnt;
        poll_e poll;
        logic [7:0] rdata;
        logic hit;
    } state_s;

    state_s st_q;
    state_s st_d;

    logic [3:0] buttons;
    logic [AXES-1:0] axis_live;
    logic [7:0] status_val;
    logic legacy_hit;
    logic status_sel;
    logic [PORTS*2-1:0] store_wr;
    logic [PORTS*2*W-1:0] store_data;
    logic [W-1:0] pos_x;
    logic [W-1:0] pos_y;
    logic stick_b_button_two;
    logic stick_b_button_one;
    logic stick_a_button_two;
    logic stick_a_button_one;
    logic stick_b_vertical_timer;
    logic stick_b_horizontal_timer;
    logic stick_a_vertical_timer;
    logic stick_a_horizontal_timer;
    logic digital_port_choice;
    logic blank_done;
    logic [AXES-1:0] run_next;
    logic [AXES-1:0][W-1:0] cnt_next;
    logic [7:0] rd_val;
    logic rd_map;

    // ========================================================================
    // live status value built from synchronised pins
    // buttons pull low when pressed; inverted so 1 reads as pressed
    assign buttons = ~st_q.sync2.button_n;
    assign axis_live = st_q.running;
    // named button fields, pin order [0]=a1 [1]=a2 [2]=b1 [3]=b2
    assign stick_a_button_one = buttons[0];
    assign stick_a_button_two = buttons[1];
    assign stick_b_button_one = buttons[2];
    assign stick_b_button_two = buttons[3];
    // named timer fields, axis order [0]=a x [1]=a y [2]=b x [3]=b y
    assign stick_a_horizontal_timer = axis_live[0];
    assign stick_a_vertical_timer = axis_live[1];
    assign stick_b_horizontal_timer = axis_live[2];
    assign stick_b_vertical_timer = axis_live[3];
    assign digital_port_choice = st_q.ctl[CTL_CHOICE_BIT];
    always_comb
    begin
        status_val = {stick_b_button_two, stick_b_button_one,
            stick_a_button_two, stick_a_button_one,
            stick_b_vertical_timer, stick_b_horizontal_timer,
            stick_a_vertical_timer, stick_a_horizontal_timer};
    end

    // ========================================================================
    // address decode; block offsets always live, legacy only when enabled
    always_comb
    begin
        legacy_hit = st_q.ctl[CTL_LEGACY_BIT] &&
            (req.addr == OFS_ALIAS_LO || req.addr == OFS_ALIAS_HI);
        status_sel = legacy_hit || req.addr == OFS_STATUS_LO ||
            req.addr == OFS_STATUS_HI;
    end

    // ========================================================================
    // per-axis capture into the position store: entries follow axis order
    // a-x, a-y feed port one, b-x, b-y feed port two
    genvar g;
    generate
        for (g = 0; g < AXES; g++)
        begin : g_axis
            assign store_wr[g] = st_q.ctl[CTL_POLL_BIT] &&
                st_q.poll == POLL_DONE;
            assign store_data[g*W +: W] = st_q.count[g];
        end
    endgenerate

    // ========================================================================
    // per-axis one-shot tracking, one counter per axis
    // limitation: the external one-shot must rise in the same clock as the
    // trigger, or the stale low behind the synchroniser ends the axis early
    assign blank_done = st_q.min_cnt >= 8'(ONESHOT_MIN_CYC);
    generate
        for (g = 0; g < AXES; g++)
        begin : g_timer
            // saturate rather than wrap on an open axis
            assign cnt_next[g] = (st_q.running[g] && st_q.count[g] != '1) ?
                st_q.count[g] + W'(1) : st_q.count[g];
            assign run_next[g] = st_q.running[g] &&
                !(!st_q.sync2.comp[g] && blank_done);
        end
    endgenerate

    axis_position_store #(
        .W(W)
    ) u_store (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(store_wr),
        .wr_data(store_data),
        .rd_port(digital_port_choice),
        .rd_x(pos_x),
        .rd_y(pos_y)
    );

    // ========================================================================
    // read mux; unmapped offsets answer zero and raise no hit
    always_comb
    begin
        rd_val = 8'h00;
        rd_map = 1'b1;
        if (status_sel)
        begin
            rd_val = status_val;
        end
        else
        begin
            unique case (req.addr)
                OFS_CONTROL:
                begin
                    rd_val = {st_q.ctl[7:4], buttons};
                end
                OFS_XPOS_LO:
                begin
                    rd_val = pos_x[7:0];
                end
                OFS_XPOS_HI:
                begin
                    rd_val = {3'b000, pos_x[W-1:8]};
                end
                OFS_YPOS_LO:
                begin
                    rd_val = pos_y[7:0];
                end
                OFS_YPOS_HI:
                begin
                    rd_val = {3'b000, pos_y[W-1:8]};
                end
                default:
                begin
                    rd_map = 1'b0;
                end
            endcase
        end
    end

    // ========================================================================
    // next-state logic
    always_comb
    begin
        st_d = st_q;
        // two-flop synchroniser on every pin input
        st_d.sync1 = pins;
        st_d.sync2 = st_q.sync1;
        st_d.trig = 1'b0;

        // host writes
        if (req.wr)
        begin
            if (status_sel)
            begin
                st_d.trig = 1'b1;
            end
            if (req.addr == OFS_CONTROL)
            begin
                // low nibble and bit 5 stay zero: writes there are dropped
                st_d.ctl[CTL_POLL_BIT] = req.wdata[CTL_POLL_BIT];
                st_d.ctl[CTL_LEGACY_BIT] = req.wdata[CTL_LEGACY_BIT];
                st_d.ctl[CTL_CHOICE_BIT] = req.wdata[CTL_CHOICE_BIT];
            end
        end

        // auto-poll fires its own trigger whenever no poll is running and none was fired last cycle
        if (st_q.ctl[CTL_POLL_BIT] && st_q.poll != POLL_RUN &&
            !st_q.trig)
        begin
            st_d.trig = 1'b1;
        end

        // axis one-shots: start on trigger, end when comparator falls
        if (st_q.trig)
        begin
            st_d.running = '1;
            st_d.count = '0;
            st_d.min_cnt = 8'h00;
            st_d.poll = POLL_RUN;
        end
        else
        begin
            if (st_q.min_cnt < 8'(ONESHOT_MIN_CYC))
            begin
                st_d.min_cnt = st_q.min_cnt + 8'h01;
            end
            // per-axis next values come from the timer generate loop
            st_d.count = cnt_next;
            st_d.running = run_next;
            unique case (st_q.poll)
                POLL_IDLE:
                begin
                    st_d.poll = POLL_IDLE;
                end
                POLL_RUN:
                begin
                    if (st_d.running == '0)
                    begin
                        st_d.poll = POLL_DONE;
                    end
                end
                POLL_DONE:
                begin
                    st_d.poll = POLL_IDLE;
                end
                default:
                begin
                    st_d.poll = POLL_IDLE;
                end
            endcase
        end

        // read data, captured one cycle after the read strobe
        st_d.hit = req.rd && rd_map;
        st_d.rdata = req.rd ? rd_val : 8'h00;
    end

    // ========================================================================
    // state register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.ctl <= CTL_RESET;
            st_q.sync1.button_n <= 4'hF;
            st_q.sync2.button_n <= 4'hF;
            st_q.poll <= POLL_IDLE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ========================================================================
    // outputs
    assign rsp.rdata = st_q.rdata;
    assign rsp.hit = st_q.hit;
    assign trigger = st_q.trig;
    assign auto_poll_enable = st_q.ctl[CTL_POLL_BIT];
    assign legacy_decode_enable = st_q.ctl[CTL_LEGACY_BIT];
endmodule // joystick_game_port

//--- testbench/joystick_game_port_chk.sv
// checker: port-level properties of the game port block
`timescale 1ns/1ps
module joystick_game_port_chk
    import game_port_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // watched ports
    input wire game_port_pkg::host_req_s req,
    input wire game_port_pkg::host_rsp_s rsp,
    input wire game_port_pkg::analog_pins_s pins,
    input wire logic trigger,
    input wire logic auto_poll_enable,
    input wire logic legacy_decode_enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========
    // triggers and decode
    a_write_trigger: assert property (
        req.wr && req.addr[9:1] == 9'h000 |=> trigger)
        else $error("no trigger after status write");
    a_legacy_quiet: assert property (
        req.wr && req.addr[9] && !legacy_decode_enable
        && !auto_poll_enable |=> !trigger)
        else $error("hidden legacy write fired trigger");
    a_legacy_hidden: assert property (
        req.rd && req.addr[9] && !legacy_decode_enable
        |=> !rsp.hit && rsp.rdata == 8'h00)
        else $error("hidden legacy read answered");
    a_hit_only_rd: assert property (
        !req.rd |=> !rsp.hit)
        else $error("hit without read");
    // ==========
    // control bits and register fields; buttons held four edges for the synchroniser
    a_poll_bit: assert property (
        req.wr && req.addr == OFS_CONTROL
        |=> auto_poll_enable == $past(req.wdata[7]))
        else $error("poll enable not written");
    a_legacy_bit: assert property (
        req.wr && req.addr == OFS_CONTROL
        |=> legacy_decode_enable == $past(req.wdata[6]))
        else $error("legacy enable not written");
    a_ctl_buttons: assert property (
        $stable(pins.button_n)[*4] ##0 (req.rd && req.addr == OFS_CONTROL)
        |=> rsp.rdata[3:0] == ~$past(pins.button_n))
        else $error("control buttons wrong");
    a_status_buttons: assert property (
        $stable(pins.button_n)[*4] ##0 (req.rd && req.addr[9:1] == 9'h000)
        |=> rsp.rdata[7:4] == ~$past(pins.button_n))
        else $error("status buttons wrong");
    a_pos_reserved: assert property (
        req.rd && (req.addr == OFS_XPOS_HI || req.addr == OFS_YPOS_HI)
        |=> rsp.rdata[7:5] == 3'h0)
        else $error("position top bits set");
    c_trigger: cover property (trigger);
    c_alias_hit: cover property (req.rd && req.addr[9] ##1 rsp.hit);
    c_polling: cover property (auto_poll_enable);
endmodule // joystick_game_port_chk

bind joystick_game_port joystick_game_port_chk chk (.mclk(mclk),
    .rst_n(rst_n), .req(req), .rsp(rsp), .pins(pins), .trigger(trigger),
    .auto_poll_enable(auto_poll_enable),
    .legacy_decode_enable(legacy_decode_enable));

//--- testbench/stick_model.sv
// analog stick model: four buttons and four axis one-shots
`timescale 1ns/1ps
module stick_model
    import game_port_pkg::*;
(
    // clock and one-shot trigger
    input wire logic mclk,
    input wire logic trigger,
    // bench stimulus
    input wire logic [3:0] pressed,
    input wire logic [31:0] len,
    // pins toward the block
    output game_port_pkg::analog_pins_s pins
);
    int cnt [4] = '{0, 0, 0, 0};
    // each axis charges for its own length after a trigger
    always @(posedge mclk)
        for (int i = 0; i < 4; i++)
            if (trigger)
                cnt[i] <= len[i*8 +: 8];
            else if (cnt[i] > 0)
                cnt[i] <= cnt[i] - 1;
    // comparator rises with the trigger pulse itself, as a real one-shot
    // does, then stays high while charging; pressed button pulls low
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pins.comp[i] = trigger || cnt[i] > 0;
        pins.button_n = ~pressed;
    end
endmodule // stick_model

//--- testbench/joystick_game_port_tb.sv
// testbench: directed scenarios for the joystick game port
`timescale 1ns/1ps
module joystick_game_port_tb;
    import game_port_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    host_req_s req = '0;
    host_rsp_s rsp;
    analog_pins_s pins;
    logic trigger, auto_poll_enable, legacy_decode_enable;
    logic [3:0] pressed = 4'h0;
    logic [31:0] len = 32'h0;
    logic [7:0] rb;
    logic hb;
    int mismatches = 0;
    int checks_done = 0;
    int trig_cnt = 0;
    int n;

    joystick_game_port dut (.mclk(mclk), .rst_n(rst_n), .req(req),
        .rsp(rsp), .pins(pins), .trigger(trigger),
        .auto_poll_enable(auto_poll_enable),
        .legacy_decode_enable(legacy_decode_enable));
    stick_model sticks (.mclk(mclk), .trigger(trigger),
        .pressed(pressed), .len(len), .pins(pins));

    // clock, and a tally of trigger pulses
    initial
    begin
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (trigger === 1'b1)
            trig_cnt++;

    // ==========
    // shared tasks; requests change only on falling edges
    task automatic check(input string w, input logic [15:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge mclk);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge mclk);
        req.wr = 1'b0;
    endtask
    // answer is registered, so it is settled by the next falling edge
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(negedge mclk);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge mclk);
        req.rd = 1'b0;
        d = rsp.rdata;
        hb = rsp.hit;
    endtask
    task automatic rdchk(input string w, input logic [9:0] a,
        input logic [7:0] e, input logic h);
        rd(a, rb);
        check(w, {8'h00, e}, {8'h00, rb});
        check(w, {15'h0, h}, {15'h0, hb});
    endtask
    // counts carry sync slack, so a small window is allowed
    task automatic near(input string w, input logic [9:0] a, input int e);
        logic [7:0] lo;
        logic [7:0] hi;
        int v;
        rd(a, lo);
        rd(a + 10'h001, hi);
        check(w, 16'h0, {13'h0, hi[7:5]});
        v = {hi[4:0], lo};
        checks_done++;
        if (v < e - 4 || v > e + 4)
        begin
            mismatches++;
            $display("unexpected %s: expected %0d seen %0d", w, e, v);
        end
    endtask

    // ==========
    // scenarios
    task automatic t_reset();
        rdchk("control", OFS_CONTROL, 8'h00, 1'b1);
        rdchk("status", OFS_STATUS_LO, 8'h00, 1'b1);
        rdchk("alias off", OFS_ALIAS_LO, 8'h00, 1'b0);
        rdchk("unmapped", 10'h100, 8'h00, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_buttons();
        for (int i = 0; i < 4; i++)
        begin
            pressed = 4'h1 << i;
            repeat (3) @(negedge mclk);
            rdchk("st btn", OFS_STATUS_HI, {pressed, 4'h0}, 1'b1);
            wr(OFS_CONTROL, 8'h0F);
            rdchk("ctl btn", OFS_CONTROL, {4'h0, pressed}, 1'b1);
        end
        $display("test buttons done");
    endtask
    task automatic t_timers();
        pressed = 4'h0;
        len = {8'd100, 8'd70, 8'd40, 8'd10};
        n = trig_cnt;
        wr(OFS_STATUS_HI, 8'hA5);
        repeat (2) @(negedge mclk);
        rdchk("all run", OFS_STATUS_LO, 8'h0F, 1'b1);
        repeat (20) @(negedge mclk);
        rdchk("ax done", OFS_STATUS_LO, 8'h0E, 1'b1);
        repeat (40) @(negedge mclk);
        rdchk("a done", OFS_STATUS_LO, 8'h0C, 1'b1);
        repeat (60) @(negedge mclk);
        rdchk("all done", OFS_STATUS_LO, 8'h00, 1'b1);
        check("one trigger", 16'(n + 1), 16'(trig_cnt));
        $display("test timers done");
    endtask
    task automatic t_legacy();
        pressed = 4'h5;
        wr(OFS_CONTROL, 8'h40);
        repeat (3) @(negedge mclk);
        rdchk("alias lo", OFS_ALIAS_LO, 8'h50, 1'b1);
        rdchk("alias hi", OFS_ALIAS_HI, 8'h50, 1'b1);
        n = trig_cnt;
        wr(OFS_ALIAS_HI, 8'h00);
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_ALIAS_LO, 8'h00);
        repeat (2) @(negedge mclk);
        check("alias trig", 16'(n + 1), 16'(trig_cnt));
        $display("test legacy done");
    endtask
    task automatic t_poll();
        pressed = 4'h0;
        len = {8'd90, 8'd70, 8'd50, 8'd30};
        wr(OFS_CONTROL, 8'h80);
        repeat (400) @(negedge mclk);
        near("a x", OFS_XPOS_LO, 30);
        near("a y", OFS_YPOS_LO, 50);
        wr(OFS_CONTROL, 8'h90);
        repeat (3) @(negedge mclk);
        near("b x", OFS_XPOS_LO, 70);
        near("b y", OFS_YPOS_LO, 90);
        $display("test poll done");
    endtask

    // ==========
    // verdict, main sequence and watchdog
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_buttons();
        t_timers();
        t_legacy();
        t_poll();
        end_of_test();
    end
    initial
    begin
        #(20 * 5000);
        mismatches++;
        end_of_test();
    end
endmodule // joystick_game_port_tb
